// ### qpic_pkg.sv
// Constants shared by the position init control block.
// Assumes a 32-bit APB with word-aligned registers.
package qpic_pkg;
  localparam int ADDR_W = 8;
  localparam int REG_W = 16;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CFG = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_INIT = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_GEC = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_POS = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_STAT = 8'h14;
  localparam int B_EN = 15;
  localparam int B_IDLE = 13;
  localparam int B_MODE_LO = 10;
  localparam int B_IMV_B = 9;
  localparam int B_IMV_A = 8;
  localparam int B_CNTPOL = 3;
  localparam int B_SWAP = 0;
  localparam int B_APOL = 1;
  localparam int B_BPOL = 2;
  localparam logic [REG_W-1:0] CTRL_WMASK = 16'hBF7F;
  localparam logic [REG_W-1:0] CTRL_RST = 16'h0000;
  localparam logic [2:0] CFG_RST = 3'h0;
  localparam logic [2:0] PM_NONE = 3'h0;
  localparam logic [2:0] PM_EVERY = 3'h1;
  localparam logic [2:0] PM_NEXT = 3'h2;
  localparam logic [2:0] PM_FIRST = 3'h3;
  localparam logic [2:0] PM_SECOND = 3'h4;
  localparam logic [2:0] PM_GE = 3'h5;
  localparam logic [2:0] PM_MOD = 3'h6;
  localparam logic [1:0] CCM_QUAD = 2'h0;
  localparam logic [1:0] CCM_EXT = 2'h1;
  localparam int SIG_A = 0;
  localparam int SIG_B = 1;
  localparam int SIG_IDX = 2;
  localparam int SIG_HOME = 3;
  localparam int NSIG = 4;
endpackage

// ### qpic_enc_if.sv
// Synchronised encoder levels and their one-cycle-old copies.
// Driven by the synchroniser, read by decoder and control.
`timescale 1ns/10ps
`default_nettype none
interface qpic_enc_if;
  logic [qpic_pkg::NSIG-1:0] lvl;
  logic [qpic_pkg::NSIG-1:0] prv;
  modport src (output lvl, output prv);
  modport dst (input lvl, input prv);
endinterface
`default_nettype wire

// ### qpic_sync.sv
// Two-flop synchroniser plus a history stage for edge detection.
// Assumes raw encoder pins may change at any time.
`timescale 1ns/10ps
`default_nettype none
module qpic_sync
  import qpic_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire logic [qpic_pkg::NSIG-1:0] raw,
  qpic_enc_if.src enc
);
  logic [NSIG-1:0] s1_r, s2_r, s3_r;
  logic [NSIG-1:0] s1_nxt, s2_nxt, s3_nxt;

  always_comb
  begin
    s1_nxt = pce ? raw : s1_r;
    s2_nxt = pce ? s1_r : s2_r;
    s3_nxt = pce ? s2_r : s3_r;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end
    else
    begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
    end
  end

  assign enc.lvl = s2_r;
  assign enc.prv = s3_r;

  hist_stage_a: assert property (@(posedge pclk) disable iff (!presetn)
    pce |=> s3_r == $past(s2_r)) else $error("history stage lags");
endmodule // qpic_sync
`default_nettype wire

// ### qpic_decode.sv
// Swap/polarity correction and count step decoding.
// Pure logic: history comes from the synchroniser.
`timescale 1ns/10ps
`default_nettype none
module qpic_decode
  import qpic_pkg::*;
(
  qpic_enc_if.dst enc,
  input wire logic swap,
  input wire logic a_pol,
  input wire logic b_pol,
  input wire logic [1:0] ccm,
  output logic eff_a,
  output logic eff_b,
  output logic step_up,
  output logic step_dn
);
  logic pa, pb, chg;

  always_comb
  begin
    eff_a = (swap ? enc.lvl[SIG_B] : enc.lvl[SIG_A]) ^ a_pol;
    eff_b = (swap ? enc.lvl[SIG_A] : enc.lvl[SIG_B]) ^ b_pol;
    pa = (swap ? enc.prv[SIG_B] : enc.prv[SIG_A]) ^ a_pol;
    pb = (swap ? enc.prv[SIG_A] : enc.prv[SIG_B]) ^ b_pol;
    // Exactly one phase moved: a double change is a lost step
    chg = (eff_a ^ pa) ^ (eff_b ^ pb);
    step_up = 1'b0;
    step_dn = 1'b0;
    if (ccm == CCM_QUAD)
    begin
      step_up = chg & (eff_a ^ pb);
      step_dn = chg & ~(eff_a ^ pb);
    end
    else if (ccm == CCM_EXT)
    begin
      step_up = eff_a & ~pa & eff_b;
      step_dn = eff_a & ~pa & ~eff_b;
    end
  end
endmodule // qpic_decode
`default_nettype wire

// ### qpic_ctrl.sv
// Position counter with index/home initialisation, APB registers.
// Assumes APB3 master, encoder pins asynchronous, idle_mode level.
`timescale 1ns/10ps
`default_nettype none
module qpic_ctrl
  import qpic_pkg::*;
#(
  parameter int POS_W = 32
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [qpic_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic phase_a_input,
  input wire logic phase_b_input,
  input wire logic index_input,
  input wire logic home_input,
  input wire logic idle_mode
);
  typedef enum logic [1:0] {HS_WAIT, HS_HOMED, HS_ONE} qpic_home_t;

  function automatic logic known(input logic [ADDR_W-1:0] a);
    known = (a == OFF_CTRL) || (a == OFF_CFG) || (a == OFF_INIT) ||
            (a == OFF_GEC) || (a == OFF_POS) || (a == OFF_STAT);
  endfunction

  qpic_enc_if enc ();
  logic eff_a, eff_b, step_up, step_dn;
  logic [REG_W-1:0] ctrl_r, ctrl_nxt;
  logic [2:0] cfg_r, cfg_nxt;
  logic [POS_W-1:0] init_r, init_nxt, gec_r, gec_nxt, pos_r, pos_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  qpic_home_t hs_r, hs_nxt;
  logic wr, wr_pos, run, upd, timer, match, idx_rise, home_rise, idx_evt;
  logic [2:0] mode;
  logic [1:0] ccm;

  qpic_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pce(pce),
    .raw({home_input, index_input, phase_b_input, phase_a_input}),
    .enc(enc)
  );

  qpic_decode u_dec (
    .enc(enc),
    .swap(cfg_r[B_SWAP]),
    .a_pol(cfg_r[B_APOL]),
    .b_pol(cfg_r[B_BPOL]),
    .ccm(ccm),
    .eff_a(eff_a),
    .eff_b(eff_b),
    .step_up(step_up),
    .step_dn(step_dn)
  );

  always_comb
  begin
    mode = ctrl_r[B_MODE_LO +: 3];
    ccm = ctrl_r[1:0];
    timer = ccm[1];
    run = ctrl_r[B_EN] & ~(ctrl_r[B_IDLE] & idle_mode);
    upd = pce & run;
    match = (eff_a == ctrl_r[B_IMV_A]) && (eff_b == ctrl_r[B_IMV_B]);
    idx_rise = enc.lvl[SIG_IDX] & ~enc.prv[SIG_IDX];
    home_rise = enc.lvl[SIG_HOME] & ~enc.prv[SIG_HOME];
    // Phase match only qualifies the index in quadrature mode
    idx_evt = idx_rise & ((ccm != CCM_QUAD) | match);
  end

  // Zero-wait slave; a frozen clock enable stretches the access
  assign pready = pce;
  assign pslverr = psel & penable & ~known(paddr);
  assign prdata = prdata_r;
  assign wr = psel & penable & pwrite & pce;
  assign wr_pos = wr & (paddr == OFF_POS);

  always_comb
  begin
    ctrl_nxt = ctrl_r;
    cfg_nxt = cfg_r;
    init_nxt = init_r;
    gec_nxt = gec_r;
    if (wr)
    begin
      case (paddr)
        OFF_CTRL: ctrl_nxt = pwdata[REG_W-1:0] & CTRL_WMASK;
        OFF_CFG: cfg_nxt = pwdata[2:0];
        OFF_INIT: init_nxt = pwdata[POS_W-1:0];
        OFF_GEC: gec_nxt = pwdata[POS_W-1:0];
        default: ;
      endcase
    end
  end

  always_comb
  begin
    prdata_nxt = prdata_r;
    if (psel && pce)
    begin
      case (paddr)
        OFF_CTRL: prdata_nxt = {16'h0000, ctrl_r};
        OFF_CFG: prdata_nxt = {29'h0, cfg_r};
        OFF_INIT: prdata_nxt = 32'(init_r);
        OFF_GEC: prdata_nxt = 32'(gec_r);
        OFF_POS: prdata_nxt = 32'(pos_r);
        OFF_STAT: prdata_nxt = {25'h0, run, 2'(hs_r), enc.lvl};
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Home tracking for the home-qualified index modes
  always_comb
  begin
    hs_nxt = hs_r;
    if (upd && !timer)
    begin
      if (mode != PM_FIRST && mode != PM_SECOND)
        hs_nxt = HS_WAIT;
      else
      begin
        case (hs_r)
          HS_WAIT: if (home_rise) hs_nxt = HS_HOMED;
          HS_HOMED:
            if (idx_evt)
              hs_nxt = (mode == PM_SECOND) ? HS_ONE : HS_WAIT;
          HS_ONE: if (idx_evt) hs_nxt = HS_WAIT;
          default: hs_nxt = HS_WAIT;
        endcase
      end
    end
  end

  always_comb
  begin
    pos_nxt = pos_r;
    if (wr_pos)
      pos_nxt = pwdata[POS_W-1:0];
    else if (upd && timer)
      // Init modes do not apply to timers
      pos_nxt = ctrl_r[B_CNTPOL] ? pos_r - 1'b1 : pos_r + 1'b1;
    else if (upd)
    begin
      if (step_up)
        pos_nxt = pos_r + 1'b1;
      else if (step_dn)
        pos_nxt = pos_r - 1'b1;
      case (mode)
        PM_NONE: ;
        PM_EVERY: if (idx_evt) pos_nxt = '0;
        PM_NEXT: if (idx_evt) pos_nxt = init_r;
        PM_FIRST: if (idx_evt && hs_r == HS_HOMED) pos_nxt = init_r;
        PM_SECOND: if (idx_evt && hs_r == HS_ONE) pos_nxt = init_r;
        PM_GE: if (pos_r == gec_r) pos_nxt = '0;
        PM_MOD:
        begin
          // Wraps between the init value and the compare value
          if (step_up && pos_r == gec_r)
            pos_nxt = init_r;
          else if (step_dn && pos_r == init_r)
            pos_nxt = gec_r;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= CTRL_RST;
      cfg_r <= CFG_RST;
      init_r <= '0;
      gec_r <= '0;
      pos_r <= '0;
      hs_r <= HS_WAIT;
      prdata_r <= '0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      cfg_r <= cfg_nxt;
      init_r <= init_nxt;
      gec_r <= gec_nxt;
      pos_r <= pos_nxt;
      hs_r <= hs_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Register side: masking, unmapped writes, read data
  ctrl_mask_a: assert property (
    wr && paddr == OFF_CTRL |=> ctrl_r == (REG_W'($past(pwdata)) & CTRL_WMASK))
    else $error("control write not masked");

  unmapped_wr_a: assert property (
    wr && !known(paddr)
    |=> $stable(ctrl_r) && $stable(cfg_r) && $stable(init_r) && $stable(gec_r))
    else $error("unmapped write changed a register");

  pos_write_a: assert property (
    wr_pos |=> pos_r == POS_W'($past(pwdata)))
    else $error("position write lost");

  read_pos_a: assert property (
    psel && !penable && pce && paddr == OFF_POS |=> prdata == 32'($past(pos_r)))
    else $error("position read data wrong");

  read_ctrl_a: assert property (
    psel && !penable && pce && paddr == OFF_CTRL |=> prdata == {16'h0000, $past(ctrl_r)})
    else $error("control read data wrong");

  rsv_bits_a: assert property (
    ctrl_r[14] == 1'b0 && ctrl_r[7] == 1'b0)
    else $error("unimplemented bits set");

  // Run gating: enable, idle stop and clock enable
  dis_hold_a: assert property (
    pce && !ctrl_r[B_EN] && !wr_pos |=> pos_r == $past(pos_r))
    else $error("counter moved while disabled");

  idle_halt_a: assert property (
    idle_mode && ctrl_r[B_IDLE] && !wr_pos |=> $stable(pos_r))
    else $error("counter moved in idle");

  run_gate_a: assert property (
    pce && !run && !wr_pos |=> $stable(pos_r) && $stable(hs_r))
    else $error("state moved while halted");

  ce_freeze_a: assert property (
    !pce |=> $stable(pos_r) && $stable(ctrl_r) && $stable(hs_r) && $stable(prdata_r))
    else $error("state moved with clock enable low");

  // Initialisation modes
  rsv_mode_a: assert property (
    upd && !timer && mode == 3'h7 && !step_up && !step_dn && !wr_pos
    |=> $stable(pos_r))
    else $error("reserved mode changed counter");

  mod_wrap_a: assert property (
    upd && !timer && mode == PM_MOD && step_up && pos_r == gec_r && !wr_pos
    |=> pos_r == $past(init_r))
    else $error("modulo wrap missing");

  mod_down_a: assert property (
    upd && !timer && mode == PM_MOD && step_dn && pos_r == init_r && !wr_pos
    |=> pos_r == $past(gec_r))
    else $error("modulo down wrap missing");

  ge_reset_a: assert property (
    upd && !timer && mode == PM_GE && pos_r == gec_r && !wr_pos
    |=> pos_r == '0)
    else $error("compare reset missing");

  home_arm_a: assert property (
    upd && !timer && (mode == PM_FIRST || mode == PM_SECOND) && hs_r == HS_WAIT
    && home_rise |=> hs_r == HS_HOMED)
    else $error("home event not tracked");

  second_arm_a: assert property (
    upd && !timer && mode == PM_SECOND && hs_r == HS_HOMED && idx_evt |=> hs_r == HS_ONE)
    else $error("first index after home not tracked");

  second_idx_a: assert property (
    upd && !timer && mode == PM_SECOND && hs_r == HS_ONE && idx_evt && !wr_pos
    |=> pos_r == $past(init_r))
    else $error("second index load missing");

  first_idx_a: assert property (
    upd && !timer && mode == PM_FIRST && hs_r == HS_HOMED && idx_evt && !wr_pos
    |=> pos_r == $past(init_r))
    else $error("first index load missing");

  next_idx_a: assert property (
    upd && !timer && mode == PM_NEXT && idx_evt && !wr_pos
    |=> pos_r == $past(init_r))
    else $error("next index load missing");

  every_idx_a: assert property (
    upd && !timer && mode == PM_EVERY && idx_evt && !wr_pos |=> pos_r == '0)
    else $error("index reset missing");

  idx_none_a: assert property (
    upd && !timer && mode == PM_NONE && idx_evt && !step_up && !step_dn && !wr_pos
    |=> $stable(pos_r))
    else $error("index moved counter in mode none");

  // Index qualification and timers
  match_lvl_a: assert property (
    ccm == CCM_QUAD && idx_evt
    |-> eff_b == ctrl_r[B_IMV_B] && eff_a == ctrl_r[B_IMV_A])
    else $error("index without phase match");

  qual_reset_a: assert property (
    upd && !timer && mode == PM_EVERY && ccm == CCM_QUAD && idx_rise && !match
    && !step_up && !step_dn && !wr_pos |=> $stable(pos_r))
    else $error("unmatched index reset counter");

  timer_mode_a: assert property (
    upd && timer && !ctrl_r[B_CNTPOL] && !wr_pos
    |=> pos_r == $past(pos_r) + 1'b1)
    else $error("timer did not count");

  timer_down_a: assert property (
    upd && timer && ctrl_r[B_CNTPOL] && !wr_pos
    |=> pos_r == $past(pos_r) - 1'b1)
    else $error("timer did not count down");

  timer_home_a: assert property (
    upd && timer |=> $stable(hs_r))
    else $error("home tracking moved in timer mode");

  single_evt_a: assert property (
    pce && idx_rise |=> !idx_rise)
    else $error("index edge seen twice");

  mod_wrap_c: cover property (upd && mode == PM_MOD && step_up && pos_r == gec_r);
  second_idx_c: cover property (upd && mode == PM_SECOND && hs_r == HS_ONE && idx_evt);
  ge_reset_c: cover property (upd && mode == PM_GE && pos_r == gec_r);
  ctrl_wr_c: cover property (wr && paddr == OFF_CTRL);
  timer_run_c: cover property (upd && timer);
endmodule // qpic_ctrl
`default_nettype wire

// ### qpic_enc_model.sv
// Encoder-side model: drives phase, index and home pins.
// Assumes the bench calls its tasks right after a rising pclk edge.
`timescale 1ns/10ps
`default_nettype none
module qpic_enc_model
(
  input wire logic pclk,
  output logic phase_a,
  output logic phase_b,
  output logic index_pin,
  output logic home_pin
);
  initial
  begin
    phase_a = 1'b0;
    phase_b = 1'b0;
    index_pin = 1'b0;
    home_pin = 1'b0;
  end

  task automatic set_ab(input logic a, input logic b);
    phase_a <= a;
    phase_b <= b;
    @(posedge pclk);
  endtask

  // Held three cycles so the synchroniser cannot miss it
  task automatic pulse(input logic home);
    if (home)
      home_pin <= 1'b1;
    else
      index_pin <= 1'b1;
    repeat (3) @(posedge pclk);
    home_pin <= 1'b0;
    index_pin <= 1'b0;
    repeat (5) @(posedge pclk);
  endtask
endmodule // qpic_enc_model
`default_nettype wire

// ### qpic_ctrl_tb.sv
// Self-checking bench for the position init control block.
// Drops pce once to freeze state; reads are checked by a separate monitor.
`timescale 1ns/10ps
`default_nettype none
module qpic_ctrl_tb;
  import qpic_pkg::*;
  logic pclk, presetn, pce, psel, penable, pwrite, idle_mode;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, p0, iv;
  logic pready, pslverr, pa, pb, pidx, phome;
  logic [32:0] e;
  logic [32:0] exp_q[$];
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;

  qpic_ctrl #(.POS_W(32)) qpic_ctrl_i (.pclk(pclk), .presetn(presetn), .pce(pce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .phase_a_input(pa),
    .phase_b_input(pb), .index_input(pidx), .home_input(phome), .idle_mode(idle_mode));
  qpic_enc_model qpic_enc_model_i (.pclk(pclk), .phase_a(pa), .phase_b(pb),
    .index_pin(pidx), .home_pin(phome));

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic report_and_stop();
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Ceiling well above the few hundred cycles the sequence needs
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      report_and_stop();
    end
  end

  always @(posedge pclk)
  begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0)
    begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
      n_tests++;
      if ({pslverr, prdata} !== e)
      begin
        n_errors++;
        $display("unexpected read at %h expected %h seen %h", paddr, e, {pslverr, prdata});
      end
    end
  end

  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [32:0] x);
    exp_q.push_back(x);
    xfer(1'b0, a, 32'h0);
  endtask

  function automatic logic [31:0] cw(input logic en, input logic idl, input logic [2:0] m,
    input logic [1:0] imv, input logic [1:0] ccm);
    return {16'h0, en, 1'b0, idl, m, imv, 6'h0, ccm};
  endfunction

  // Start from a known position, fire home and index events, read back
  task automatic cs(input logic [31:0] c, input logic [31:0] g, input int h, input int i,
    input logic [31:0] x);
    xfer(1'b1, OFF_CFG, g);
    xfer(1'b1, OFF_CTRL, c);
    xfer(1'b1, OFF_POS, p0);
    repeat (h) qpic_enc_model_i.pulse(1'b1);
    repeat (i) qpic_enc_model_i.pulse(1'b0);
    rd(OFF_POS, {1'b0, x});
  endtask

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    idle_mode = 1'b1;
    pce = 1'b1;
    void'($urandom(62));
    p0 = $urandom() | 32'h1;
    iv = ($urandom() | 32'h2) & 32'hFFFFFFFE;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFF_CTRL, 33'h0);
    rd(OFF_POS, 33'h0);
    rd(8'h40, {1'b1, 32'h0});
    xfer(1'b1, OFF_CTRL, 32'hFFFF);
    rd(OFF_CTRL, {17'h0, CTRL_WMASK});
    xfer(1'b1, OFF_CTRL, iv);
    rd(OFF_CTRL, {17'h0, iv[15:0] & CTRL_WMASK});
    xfer(1'b1, OFF_INIT, iv);
    xfer(1'b1, OFF_GEC, p0);
    qpic_enc_model_i.set_ab(1'b1, 1'b0);
    cs(cw(1'b1, 1'b0, PM_NONE, 2'b01, CCM_QUAD), 32'h0, 0, 1, p0);
    cs(cw(1'b1, 1'b0, PM_EVERY, 2'b01, CCM_QUAD), 32'h0, 0, 1, 32'h0);
    cs(cw(1'b1, 1'b0, PM_EVERY, 2'b11, CCM_QUAD), 32'h0, 0, 1, p0);
    cs(cw(1'b1, 1'b0, PM_EVERY, 2'b00, CCM_QUAD), 32'h0, 0, 1, p0);
    cs(cw(1'b1, 1'b0, PM_EVERY, 2'b10, CCM_QUAD), 32'h1, 0, 1, 32'h0);
    cs(cw(1'b0, 1'b0, PM_EVERY, 2'b01, CCM_QUAD), 32'h0, 0, 1, p0);
    cs(cw(1'b1, 1'b0, PM_NEXT, 2'b01, CCM_QUAD), 32'h0, 0, 1, iv);
    cs(cw(1'b1, 1'b0, PM_FIRST, 2'b01, CCM_QUAD), 32'h0, 0, 1, p0);
    cs(cw(1'b1, 1'b0, PM_FIRST, 2'b01, CCM_QUAD), 32'h0, 1, 1, iv);
    cs(cw(1'b1, 1'b0, PM_NONE, 2'b01, CCM_QUAD), 32'h0, 0, 0, p0);
    cs(cw(1'b1, 1'b0, PM_SECOND, 2'b01, CCM_QUAD), 32'h0, 1, 1, p0);
    cs(cw(1'b1, 1'b0, PM_NONE, 2'b01, CCM_QUAD), 32'h0, 0, 0, p0);
    cs(cw(1'b1, 1'b0, PM_SECOND, 2'b01, CCM_QUAD), 32'h0, 1, 2, iv);
    cs(cw(1'b1, 1'b0, PM_GE, 2'b01, CCM_QUAD), 32'h0, 0, 0, 32'h0);
    cs(cw(1'b1, 1'b0, 3'h7, 2'b01, CCM_QUAD), 32'h0, 1, 1, p0);
    // Modulo: one up step at the compare value, then one down step at init
    xfer(1'b1, OFF_CTRL, cw(1'b1, 1'b0, PM_MOD, 2'b01, CCM_QUAD));
    xfer(1'b1, OFF_POS, p0);
    qpic_enc_model_i.set_ab(1'b1, 1'b1);
    repeat (4) @(posedge pclk);
    rd(OFF_POS, {1'b0, iv});
    qpic_enc_model_i.set_ab(1'b1, 1'b0);
    repeat (4) @(posedge pclk);
    rd(OFF_POS, {1'b0, p0});
    // Timer runs every cycle in idle when idle stop is clear, index ignored
    cs(cw(1'b1, 1'b0, PM_EVERY, 2'b01, 2'b10), 32'h0, 0, 1, p0 + 32'd9);
    // Clock enable low for ten cycles freezes the running timer
    xfer(1'b1, OFF_POS, p0);
    pce <= 1'b0;
    repeat (10) @(posedge pclk);
    pce <= 1'b1;
    rd(OFF_POS, {1'b0, p0 + 32'd1});
    cs(cw(1'b1, 1'b1, PM_EVERY, 2'b01, 2'b10), 32'h0, 0, 1, p0);
    repeat (4) @(posedge pclk);
    report_and_stop();
  end
endmodule // qpic_ctrl_tb
`default_nettype wire
